/* File: src/eipv_pkg.sv */
package eipv_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_EDGE_ENABLE = 10'h0ca;
    localparam logic [9:0] IDX_REQ_FLAGS = 10'h0cc;
    localparam logic [9:0] IDX_CTRL = 10'h0d8;
    localparam logic [9:0] IDX_SRC_ENABLE = 10'h0d9;
    localparam logic [9:0] IDX_TMR_FLAGS = 10'h0da;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h0db;
    localparam logic [9:0] IDX_EVT_MASK = 10'h0dc;
    localparam logic [9:0] IDX_VEC_STATUS = 10'h0dd;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [5:0] EDGE_ENABLE_RST = 6'h00;
    localparam logic [2:0] REQ_FLAGS_RST = 3'h0;
    localparam logic [5:0] SRC_ENABLE_RST = 6'h00;
    localparam logic [3:0] EVT_RST = 4'h0;
    localparam int LINES = 3;
    localparam int TMR_SRCS = 6;
    localparam int EVT_VEC = 3;
    localparam int VEC_BUSY_BIT = 4;

    // edge select codes of one line's two-bit field
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // vector slots; a higher slot number wins, vector base + 2 * slot
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_BASE = 16'hffe0;
    localparam int SLOTS = 16;
    localparam int SLOT_RESET = 15;
    localparam int SLOT_LINE_A = 14;
    localparam int SLOT_LINE_B = 13;
    localparam int SLOT_LINE_C = 12;
    // timer sources occupy slots 0..5:
    // 0 interval timer, 1 watchdog, 2 t3 ovf, 3 t3 match,
    // 4 t2 ovf, 5 t2 match

    // ------------------------------------------------------------
    // acceptance timing, in oscillator (system clock) cycles
    // ------------------------------------------------------------
    localparam int ACCEPT_CYCLES = 8;
    localparam logic [3:0] ACCEPT_LAST = 4'(ACCEPT_CYCLES - 1);

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        EIPV_IDLE = 3'b001,
        EIPV_ACCEPT = 3'b010,
        EIPV_VECTOR = 3'b100
    } eipv_state_t;

endpackage

/* File: src/eipv_top.sv */
`timescale 1ns/1ps

// Function
// - vector address is base plus two times slot, reset at top.
// - fixed priority: reset, lines a b c, timers, watchdog, interval.
// - every external line is edge triggered, rising, falling or both.
// - field code 00 off, 01 falling, 10 rising, 11 both edges.
// - line c in bits 5:4, b in 3:2, a in 1:0, 7:6 zero.
// - one pending flag per line, low three bits, upper bits zero.
// - vectoring clears a line's flag only if an edge raised it.
// - a selected edge on an enabled line requests its service.
// - acceptance takes eight cycles, clears mask and flag, then vector.
// - higher priority served first; fixed scan order breaks ties.
// - maskable requests wait while the global mask flag is clear.
module eipv_top
    import eipv_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // external interrupt pins
    input wire logic line_a_pin_i,
    input wire logic line_b_pin_i,
    input wire logic line_c_pin_i,
    // on-chip timer request pulses
    input wire logic bit_ovf_i,
    input wire logic wdt_match_i,
    input wire logic t3_ovf_i,
    input wire logic t3_match_i,
    input wire logic t2_ovf_i,
    input wire logic t2_match_i,
    // processor core
    input wire logic instr_done_i,
    input wire logic global_enable_instruction_i,
    input wire logic global_disable_i,
    output logic irq_pending_o,
    output logic accept_busy_o,
    output logic vector_valid_o,
    output logic [15:0] vector_addr_o,
    output logic global_enable_o,
    // interrupt to software
    output logic irq_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LINES-1:0] sync1;
        logic [LINES-1:0] sync2;
        logic [LINES-1:0] prev;
        logic [2*LINES-1:0] edge_en;
        logic [LINES-1:0] ext_flag;
        logic [LINES-1:0] ext_edge;
        logic [TMR_SRCS-1:0] tmr_flag;
        logic [TMR_SRCS-1:0] src_en;
        logic iflag;
        logic rst_pend;
        logic [3:0] evt;
        logic [3:0] evt_mask;
        eipv_state_t state;
        logic [3:0] cnt;
        logic [3:0] slot;
        logic [15:0] vec;
        logic wr_pend;
        logic [9:0] wr_idx;
        logic [31:0] rdata;
    } eipv_regs_t;

    eipv_regs_t r;
    eipv_regs_t next_r;

    logic [LINES-1:0] pins;
    logic [TMR_SRCS-1:0] tmr_in;

    assign pins = {line_c_pin_i, line_b_pin_i, line_a_pin_i};
    assign tmr_in = {t2_match_i, t2_ovf_i, t3_match_i, t3_ovf_i,
                     wdt_match_i, bit_ovf_i};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [LINES-1:0] edge_hit;
        logic [SLOTS-1:0] cand;
        logic [3:0] win;
        logic any;
        logic rd_take;
        logic [9:0] rd_idx;
        logic [31:0] rd_val;
        logic [1:0] mode;
        logic rise;
        logic fall;
        edge_hit = '0;
        cand = '0;
        win = '0;
        any = 1'b0;
        rd_take = 1'b0;
        rd_idx = '0;
        rd_val = '0;
        mode = EDGE_OFF;
        rise = 1'b0;
        fall = 1'b0;
        next_r = r;

        // first stage feeds only the second stage
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;

        // edge detection on consecutive synchronised samples
        for (int i = 0; i < LINES; i++) begin
            mode = r.edge_en[2*i +: 2];
            rise = r.sync2[i] & ~r.prev[i];
            fall = ~r.sync2[i] & r.prev[i];
            case (mode)
                EDGE_FALL: edge_hit[i] = fall;
                EDGE_RISE: edge_hit[i] = rise;
                EDGE_BOTH: edge_hit[i] = rise | fall;
                default: edge_hit[i] = 1'b0;
            endcase
        end

        // global mask flag: core instructions, enable wins over disable
        if (global_enable_instruction_i) begin
            next_r.iflag = 1'b1;
        end else if (global_disable_i) begin
            next_r.iflag = 1'b0;
        end

        // candidate requests, maskable ones gated by the mask flag
        cand[SLOT_RESET] = r.rst_pend;
        cand[SLOT_LINE_A] = r.ext_flag[0] & r.iflag;
        cand[SLOT_LINE_B] = r.ext_flag[1] & r.iflag;
        cand[SLOT_LINE_C] = r.ext_flag[2] & r.iflag;
        cand[TMR_SRCS-1:0] = r.tmr_flag & r.src_en & {TMR_SRCS{r.iflag}};

        // later slot overrides, so the highest slot wins
        for (int i = 0; i < SLOTS; i++) begin
            if (cand[i]) begin
                win = 4'(i);
                any = 1'b1;
            end
        end

        // ---- bus write, data phase ----
        if (r.wr_pend) begin
            case (r.wr_idx)
                IDX_EDGE_ENABLE: next_r.edge_en = hwdata_i[2*LINES-1:0];
                IDX_REQ_FLAGS: begin
                    // a software-set flag is not transition-activated
                    next_r.ext_flag = hwdata_i[LINES-1:0];
                    next_r.ext_edge = r.ext_edge & hwdata_i[LINES-1:0];
                end
                IDX_CTRL: next_r.iflag = hwdata_i[0];
                IDX_SRC_ENABLE: next_r.src_en = hwdata_i[TMR_SRCS-1:0];
                IDX_TMR_FLAGS: next_r.tmr_flag = hwdata_i[TMR_SRCS-1:0];
                IDX_EVT_MASK: next_r.evt_mask = hwdata_i[3:0];
                default: begin
                end
            endcase
        end

        // ---- acceptance sequence ----
        next_r.wr_pend = 1'b0;
        case (r.state)
            EIPV_IDLE: begin
                if (any && (instr_done_i || win == 4'(SLOT_RESET))) begin
                    next_r.state = EIPV_ACCEPT;
                    next_r.cnt = ACCEPT_LAST;
                    next_r.slot = win;
                    next_r.vec = VEC_BASE + {11'h000, win, 1'b0};
                    next_r.iflag = 1'b0;
                    if (win == 4'(SLOT_RESET)) begin
                        next_r.rst_pend = 1'b0;
                    end else if (win >= 4'(SLOT_LINE_C)) begin
                        // slot 14 is line a, 13 line b, 12 line c
                        for (int i = 0; i < LINES; i++) begin
                            if (win == 4'(SLOT_LINE_A - i) &&
                                r.ext_edge[i]) begin
                                next_r.ext_flag[i] = 1'b0;
                                next_r.ext_edge[i] = 1'b0;
                            end
                        end
                    end else begin
                        next_r.tmr_flag[win[2:0]] = 1'b0;
                    end
                end
            end
            EIPV_ACCEPT: begin
                // the core pushes return address and status meanwhile
                if (r.cnt == 4'h0) begin
                    next_r.state = EIPV_VECTOR;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            EIPV_VECTOR: begin
                next_r.state = EIPV_IDLE;
                next_r.evt[EVT_VEC] = 1'b1;
            end
            default: begin
                next_r.state = EIPV_IDLE;
            end
        endcase

        // hardware sets win over software or vectoring clears
        for (int i = 0; i < LINES; i++) begin
            if (edge_hit[i]) begin
                next_r.ext_flag[i] = 1'b1;
                next_r.ext_edge[i] = 1'b1;
            end
        end
        next_r.tmr_flag = next_r.tmr_flag | tmr_in;

        // ---- bus address phase ----
        if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
            rd_idx = haddr_i[11:2];
            if (hwrite_i) begin
                next_r.wr_pend = 1'b1;
                next_r.wr_idx = rd_idx;
            end else begin
                rd_take = 1'b1;
            end
        end

        // read value, unmapped and reserved bits read as zero
        case (rd_idx)
            IDX_EDGE_ENABLE: rd_val = {26'h000_0000, r.edge_en};
            IDX_REQ_FLAGS: rd_val = {29'h0000_0000, r.ext_flag};
            IDX_CTRL: rd_val = {31'h0000_0000, r.iflag};
            IDX_SRC_ENABLE: rd_val = {26'h000_0000, r.src_en};
            IDX_TMR_FLAGS: rd_val = {26'h000_0000, r.tmr_flag};
            IDX_EVT_STATUS: rd_val = {28'h000_0000, r.evt};
            IDX_EVT_MASK: rd_val = {28'h000_0000, r.evt_mask};
            IDX_VEC_STATUS: rd_val = {27'h000_0000,
                                      (r.state != EIPV_IDLE), r.slot};
            default: rd_val = 32'h0000_0000;
        endcase

        if (rd_take) begin
            next_r.rdata = rd_val;
            // read-to-clear; an event in this same cycle survives
            if (rd_idx == IDX_EVT_STATUS) begin
                next_r.evt = next_r.evt & ~r.evt;
            end
        end

        // sticky events set last so they win over the read clear
        next_r.evt[LINES-1:0] = next_r.evt[LINES-1:0] | edge_hit;
        if (r.state == EIPV_VECTOR) begin
            next_r.evt[EVT_VEC] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r.sync1 <= '0;
            r.sync2 <= '0;
            r.prev <= '0;
            r.edge_en <= EDGE_ENABLE_RST;
            r.ext_flag <= REQ_FLAGS_RST;
            r.ext_edge <= '0;
            r.tmr_flag <= '0;
            r.src_en <= SRC_ENABLE_RST;
            r.iflag <= 1'b0;
            r.rst_pend <= 1'b1;
            r.evt <= EVT_RST;
            r.evt_mask <= EVT_RST;
            r.state <= EIPV_IDLE;
            r.cnt <= '0;
            r.slot <= '0;
            r.vec <= '0;
            r.wr_pend <= 1'b0;
            r.wr_idx <= '0;
            r.rdata <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero wait states; read data is registered at the address phase
    assign hreadyout_o = 1'b1;
    assign hresp_o = HRESP_OKAY;
    assign hrdata_o = r.rdata;

    // pending request that the core will take at its next boundary
    assign irq_pending_o = (r.state == EIPV_IDLE) &&
                           (r.rst_pend ||
                            (r.iflag && ((|r.ext_flag) ||
                                         (|(r.tmr_flag & r.src_en)))));
    assign accept_busy_o = (r.state != EIPV_IDLE);
    assign vector_valid_o = (r.state == EIPV_VECTOR);
    assign vector_addr_o = r.vec;
    assign global_enable_o = r.iflag;
    assign irq_o = |(r.evt & r.evt_mask);

endmodule

/* File: bench/eipv_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// acceptance checks at the top ports
// ----------------------------------------
module eipv_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // core side
    input wire logic instr_done_i,
    input wire logic global_enable_instruction_i,
    input wire logic irq_pending_o,
    input wire logic accept_busy_o,
    input wire logic vector_valid_o,
    input wire logic [15:0] vector_addr_o,
    input wire logic global_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // eight busy cycles, then the vector cycle
    property p_seq;
        $rose(accept_busy_o) |-> (accept_busy_o && !vector_valid_o)[*8]
            ##1 vector_valid_o ##1 !accept_busy_o;
    endproperty
    a_seq: assert property (p_seq) else $error("accept length");
    // reserved slots never come out
    property p_vec;
        vector_valid_o |-> vector_addr_o[15:5] == 11'h7ff &&
            !vector_addr_o[0] && !(vector_addr_o inside {[16'hffec:16'hfff6]});
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_mask;
        $rose(accept_busy_o) |-> !global_enable_o;
    endproperty
    a_mask: assert property (p_mask) else $error("mask kept");
    // only the reset slot may skip the mask flag and the boundary
    property p_gate;
        $rose(accept_busy_o) && vector_addr_o != 16'hfffe
            |-> $past(global_enable_o && instr_done_i);
    endproperty
    a_gate: assert property (p_gate) else $error("masked accept");
    property p_idle;
        irq_pending_o |-> !accept_busy_o;
    endproperty
    a_idle: assert property (p_idle) else $error("pending busy");
    property p_take;
        irq_pending_o && instr_done_i |=> $rose(accept_busy_o);
    endproperty
    a_take: assert property (p_take) else $error("not taken");
    property p_hold;
        accept_busy_o && $past(accept_busy_o) |-> $stable(vector_addr_o);
    endproperty
    a_hold: assert property (p_hold) else $error("vector moved");
    property p_ei;
        global_enable_instruction_i && !irq_pending_o |=> global_enable_o;
    endproperty
    a_ei: assert property (p_ei) else $error("mask not set");
    property p_one;
        vector_valid_o |=> !vector_valid_o;
    endproperty
    a_one: assert property (p_one) else $error("valid too long");
endmodule

/* File: bench/eipv_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// core model: boundaries and mask set
// ----------------------------------------
module eipv_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench controls
    input wire logic slow_i,
    input wire logic auto_ei_i,
    input wire logic ei_req_i,
    // block side
    input wire logic vector_valid_i,
    output logic instr_done_o,
    output logic ei_o
);
    logic ph;
    // service routine re-enables the mask flag once vectored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ph <= 1'b0;
            ei_o <= 1'b0;
        end else begin
            ph <= !ph;
            ei_o <= ei_req_i || (auto_ei_i && vector_valid_i);
        end
    end
    // slow core reaches a boundary every other cycle only
    assign instr_done_o = slow_i ? ph : 1'b1;
endmodule

/* File: bench/tb_edge_irq_priority_vector.sv */
`timescale 1ns/1ps
module tb_edge_irq_priority_vector;
    import eipv_pkg::*;
    logic clk_i = 0, rst_n_i = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, d, ev;
    logic [2:0] pin = 0;
    logic [5:0] tmr = 0;
    logic ei_req = 0, auto_ei = 0, slow = 0, rd_dp = 0, gdis = 0;
    wire logic hrdy, hresp, irq_p, busy, vv, ge, irq, done, ei;
    wire logic [31:0] hrdata;
    wire logic [15:0] va;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    int seed = 32'h4da0_f7dc;
    logic [31:0] exp_rd[$];
    logic [31:0] exp_vec[$];
    logic [15:0] vord[9] = '{16'hfffc, 16'hfffa, 16'hfff8, 16'hffea,
        16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0};
    always #50 clk_i = ~clk_i;
    eipv_top dut_u (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hresp_o(hresp), .hrdata_o(hrdata), .line_a_pin_i(pin[0]),
        .line_b_pin_i(pin[1]), .line_c_pin_i(pin[2]), .bit_ovf_i(tmr[0]),
        .wdt_match_i(tmr[1]), .t3_ovf_i(tmr[2]), .t3_match_i(tmr[3]),
        .t2_ovf_i(tmr[4]), .t2_match_i(tmr[5]), .instr_done_i(done),
        .global_enable_instruction_i(ei), .global_disable_i(gdis),
        .irq_pending_o(irq_p), .accept_busy_o(busy), .vector_valid_o(vv),
        .vector_addr_o(va), .global_enable_o(ge), .irq_o(irq));
    eipv_core_model core_u (.clk_i, .rst_n_i, .slow_i(slow),
        .auto_ei_i(auto_ei), .ei_req_i(ei_req), .vector_valid_i(vv),
        .instr_done_o(done), .ei_o(ei));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // ahb-lite single word transfer
    // ----------------------------------------
    task bus(input logic [9:0] idx, input logic w, input logic [31:0] v);
        haddr <= {20'h0_0000, idx, 2'b00};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? v : 32'h0000_0000;
        rd_dp <= !w;
        if (!w) exp_rd.push_back(v);
        do @(posedge clk_i); while (hrdy !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    // bounded wait until every noted vector has come out
    task wait_vec;
        for (int i = 0; i < 300 && exp_vec.size() > 0; i++) @(posedge clk_i);
        // a vector that never came out counts against the run
        chk(32'(exp_vec.size()), 0);
    endtask
    // irq is a level; look mid-cycle, hand back just after a rising edge
    task chk_irq(input logic e);
        @(negedge clk_i);
        chk({31'h0000_0000, irq}, {31'h0000_0000, e});
        @(posedge clk_i);
    endtask
    // monitor: mid-cycle, where read data and vectors have settled
    always @(negedge clk_i) begin
        if (rd_dp) begin
            chk(hrdata, exp_rd.pop_front());
            chk(32'(hresp), 32'(HRESP_OKAY));
        end
        if (vv) begin
            ev = exp_vec.size() ? exp_vec.pop_front() : '1;
            chk({16'h0000, va}, ev);
        end
    end
    // hang guard, well above the planned run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        exp_vec.push_back(16'hfffe);
        bus(IDX_EDGE_ENABLE, 0, 0);
        bus(IDX_REQ_FLAGS, 0, 0);
        bus(10'h3ff, 0, 0);
        d = $random(seed);
        bus(IDX_EDGE_ENABLE, 1, d);
        bus(IDX_EDGE_ENABLE, 0, d & 32'h0000_003f);
        $display("test registers done");
        // every edge code on every line, mask flag still clear
        for (int l = 0; l < 3; l++) begin
            for (int c = 0; c < 4; c++) begin
                bus(IDX_EDGE_ENABLE, 1, 32'(c) << (2 * l));
                pin[l] <= 1'b1;
                repeat (5) @(posedge clk_i);
                bus(IDX_REQ_FLAGS, 0, 32'(c / 2) << l);
                bus(IDX_REQ_FLAGS, 1, 0);
                pin[l] <= 1'b0;
                repeat (5) @(posedge clk_i);
                bus(IDX_REQ_FLAGS, 0, 32'(c % 2) << l);
                bus(IDX_REQ_FLAGS, 1, 0);
            end
        end
        $display("test edges done");
        // all sources at once, held off until the mask flag is set
        bus(IDX_EDGE_ENABLE, 1, 32'h0000_003f);
        bus(IDX_SRC_ENABLE, 1, 32'h0000_003f);
        pin <= 3'b111;
        tmr <= 6'h3f;
        @(posedge clk_i);
        tmr <= 6'h00;
        slow <= 1'b1;
        repeat (20) @(posedge clk_i);
        foreach (vord[i]) exp_vec.push_back(vord[i]);
        auto_ei <= 1'b1;
        ei_req <= 1'b1;
        @(posedge clk_i);
        ei_req <= 1'b0;
        wait_vec();
        auto_ei <= 1'b0;
        bus(IDX_REQ_FLAGS, 0, 0);
        bus(IDX_TMR_FLAGS, 0, 0);
        // a software-set flag survives its own vectoring; the mask flag
        // is set before the write, so a late set cannot re-accept it
        ei_req <= 1'b1;
        @(posedge clk_i);
        ei_req <= 1'b0;
        bus(IDX_REQ_FLAGS, 1, 1);
        exp_vec.push_back(16'hfffc);
        wait_vec();
        repeat (3) @(posedge clk_i);
        bus(IDX_REQ_FLAGS, 0, 1);
        bus(IDX_REQ_FLAGS, 1, 0);
        $display("test priority done");
        // mask flag: software write, then the core's disable pulse
        bus(IDX_CTRL, 1, 1);
        bus(IDX_CTRL, 0, 1);
        gdis <= 1'b1;
        @(posedge clk_i);
        gdis <= 1'b0;
        bus(IDX_CTRL, 0, 0);
        $display("test mask flag done");
        // event status, mask and the level interrupt
        bus(IDX_EVT_MASK, 1, 1);
        bus(IDX_EVT_STATUS, 0, 32'h0000_000f);
        bus(IDX_EVT_STATUS, 0, 0);
        chk_irq(1'b0);
        pin[0] <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk_irq(1'b1);
        bus(IDX_EVT_MASK, 1, 0);
        chk_irq(1'b0);
        bus(IDX_EVT_STATUS, 1, 32'h0000_000f);
        bus(IDX_EVT_STATUS, 0, 1);
        bus(IDX_EVT_STATUS, 0, 0);
        $display("test interrupt done");
        end_of_test();
    end
endmodule
bind eipv_top eipv_props u_props (.clk_i, .rst_n_i, .instr_done_i,
    .global_enable_instruction_i, .irq_pending_o, .accept_busy_o,
    .vector_valid_o, .vector_addr_o, .global_enable_o);
